/* core/ddc_decoder.sv */
// Command decoder and clock-enable state logic of a DDR3 memory device.
// Assumes the memory clock, its reset pin and all command pins are
// asynchronous to clk and far slower, so edges are found by sampling.
//
// Overview of operation
// - Decode strobes and clock enable at clock rise
// - Reset pin low clears state, no clock
// - Termination input plays no part in decoding
// - Mode set: bank picks register, address opcode
// - Bank operations touch only the named bank, save precharge all
// - Self refresh exit seen without memory clock
// - Started bursts always run to their end
// - Mode zero burst; A12 chop, A10 precharge
// - Refresh, precharge, activate, write, read encodings
// - No-operation registers nothing, stops nothing
// - Deselect acts exactly like no-operation
// - No internal refresh during power-down
// - Long calibration runs engine, then updates drivers
// - Enable low holds; low-to-high with no-op exits
// - Enable falling with no-op enters power-down; with refresh, when closed, self refresh
// - Idle only when closed, quiet, enabled, settled
`timescale 1ns/100ps

module ddc_decoder (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic               ck_pin,
    input  wire logic               rst_pin_n,
    input  wire ddc_pkg::ddc_pins_t pins,
    output ddc_pkg::ddc_dec_t       dec_q,
    output logic                    dec_valid_q,
    output ddc_pkg::ddc_pwr_t       pwr_q,
    output logic [7:0]              bank_open_q,
    output logic [1:0]              mr0_bl_q,
    output logic                    burst_busy_q,
    output logic                    idle_q,
    output logic                    self_ref_tick_q,
    output logic                    zq_busy_q,
    output logic                    zq_update_q
);

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    logic [25:0]        sy;         // Filtered pins
    logic               ck_s;       // Filtered memory clock
    logic               rpin_s;     // Filtered reset pin
    ddc_pkg::ddc_pins_t p;          // Filtered command pins

    ddc_sync #(.W(26)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  ({ck_pin, rst_pin_n, pins}),
        .dout (sy)
    );

    assign ck_s   = sy[25];
    assign rpin_s = sy[24];
    assign p      = ddc_pkg::ddc_pins_t'(sy[23:0]);

    // ------------------------------------------------------------------
    // Reset and clock edge
    // ------------------------------------------------------------------
    logic srst;         // Combined reset
    logic ck_prev_q;    // Memory clock at previous clk
    logic ck_rise;      // Memory clock rising edge
    logic cke_prev_q;   // Clock enable at previous memory edge

    // Reset pin needs no memory clock to act
    assign srst    = !rstn || !rpin_s;
    assign ck_rise = ck_s && !ck_prev_q;

    // Edge history; clock enable kept per memory edge
    always_ff @(posedge clk) begin
        if (srst) begin
            ck_prev_q  <= 1'b0;
            cke_prev_q <= 1'b0;
        end else begin
            ck_prev_q <= ck_s;
            if (ck_rise) begin
                cke_prev_q <= p.cke;
            end
        end
    end

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    logic [2:0]        strb;       // RAS, CAS, WE strobes
    logic              sel;        // Chip selected
    logic              quiet;      // Deselect or no-operation
    logic              all_closed; // No bank open and no burst
    logic              chop_c;     // Burst chop for this command
    ddc_pkg::ddc_cmd_t cmd_c;      // Decoded command

    assign strb       = {p.ras_n, p.cas_n, p.we_n};
    assign sel        = !p.cs_n;
    // Deselect counts exactly as no-operation
    assign quiet      = !sel || (strb == 3'b111);
    assign all_closed = (bank_open_q == 8'h00) && !burst_busy_q;

    // Burst size from mode zero or per command
    always_comb begin
        chop_c = 1'b0;
        if (mr0_bl_q == ddc_pkg::BL_FIX4) begin
            chop_c = 1'b1;
        end else if (mr0_bl_q == ddc_pkg::BL_OTF) begin
            chop_c = !p.addr[ddc_pkg::CHOP_BIT];
        end
    end

    // Termination input is not a port; it cannot steer this
    always_comb begin
        cmd_c = ddc_pkg::CMD_NONE;
        if (pwr_q == ddc_pkg::PS_SELF && p.cke) begin
            // Exit found on the enable level alone
            cmd_c = ddc_pkg::CMD_SR_EXIT;
        end else if (ck_rise) begin
            case (pwr_q)
                ddc_pkg::PS_ACTIVE: begin
                    if (cke_prev_q && p.cke && sel) begin
                        case (strb)
                            3'b000: cmd_c = ddc_pkg::CMD_MODE_SET;
                            3'b001: cmd_c = ddc_pkg::CMD_REFRESH;
                            3'b010: cmd_c = p.addr[ddc_pkg::AP_BIT] ?
                                ddc_pkg::CMD_PRE_ALL : ddc_pkg::CMD_PRE_ONE;
                            3'b011: cmd_c = ddc_pkg::CMD_ACTIVATE;
                            3'b100: cmd_c = ddc_pkg::CMD_WRITE;
                            3'b101: cmd_c = ddc_pkg::CMD_READ;
                            3'b110: cmd_c = p.addr[ddc_pkg::AP_BIT] ?
                                ddc_pkg::CMD_CAL_LONG :
                                ddc_pkg::CMD_CAL_SHRT;
                            default: cmd_c = ddc_pkg::CMD_NONE;
                        endcase
                    end else if (cke_prev_q && !p.cke) begin
                        if (sel && strb == 3'b001 && all_closed) begin
                            cmd_c = ddc_pkg::CMD_SR_ENTER;
                        end else if (quiet) begin
                            cmd_c = ddc_pkg::CMD_PD_ENTER;
                        end
                    end
                end
                ddc_pkg::PS_PD_ACT, ddc_pkg::PS_PD_PRE: begin
                    if (!cke_prev_q && p.cke && quiet) begin
                        cmd_c = ddc_pkg::CMD_PD_EXIT;
                    end
                end
                default: cmd_c = ddc_pkg::CMD_NONE;
            endcase
        end
    end

    // Report register; one pulse per decoded command
    always_ff @(posedge clk) begin
        if (srst) begin
            dec_q       <= '0;
            dec_valid_q <= 1'b0;
        end else begin
            dec_valid_q   <= (cmd_c != ddc_pkg::CMD_NONE);
            dec_q.cmd     <= cmd_c;
            dec_q.bank    <= p.ba;
            dec_q.addr    <= p.addr;
            dec_q.chop    <= chop_c;
            dec_q.auto_pre <= p.addr[ddc_pkg::AP_BIT];
        end
    end

    // Mode register zero burst field
    always_ff @(posedge clk) begin
        if (srst) begin
            mr0_bl_q <= ddc_pkg::MR0_RST;
        end else if (cmd_c == ddc_pkg::CMD_MODE_SET &&
                     p.ba == ddc_pkg::MR0_SEL) begin
            mr0_bl_q <= p.addr[ddc_pkg::MR0_BL_LSB +: 2];
        end
    end

    // ------------------------------------------------------------------
    // Burst tracking
    // ------------------------------------------------------------------
    logic [2:0] burst_cnt_q;   // Memory edges left in burst
    logic       ap_pend_q;     // Auto precharge at burst end
    logic [2:0] ap_bank_q;     // Bank to close at burst end
    logic       burst_end;     // Last edge of the burst

    assign burst_end = ck_rise && (burst_cnt_q == 3'h1);

    // A new read or write cannot cut a running burst
    always_ff @(posedge clk) begin
        if (srst) begin
            burst_cnt_q  <= 3'h0;
            ap_pend_q    <= 1'b0;
            ap_bank_q    <= 3'h0;
            burst_busy_q <= 1'b0;
        end else begin
            if ((cmd_c == ddc_pkg::CMD_READ ||
                 cmd_c == ddc_pkg::CMD_WRITE) && !burst_busy_q) begin
                burst_cnt_q  <= chop_c ? ddc_pkg::BC4_CK :
                                         ddc_pkg::BL8_CK;
                ap_pend_q    <= p.addr[ddc_pkg::AP_BIT];
                ap_bank_q    <= p.ba;
                burst_busy_q <= 1'b1;
            end else if (ck_rise && burst_busy_q) begin
                burst_cnt_q  <= burst_cnt_q - 3'h1;
                burst_busy_q <= !burst_end;
            end
        end
    end

    // ------------------------------------------------------------------
    // Bank state
    // ------------------------------------------------------------------
    logic [7:0] bank_d;   // Next open-bank mask

    // Only the addressed bank and, at burst end, the auto-precharge bank change; precharge all clears every bank
    always_comb begin
        bank_d = bank_open_q;
        if (burst_end && ap_pend_q) begin
            bank_d[ap_bank_q] = 1'b0;
        end
        case (cmd_c)
            ddc_pkg::CMD_ACTIVATE: bank_d[p.ba] = 1'b1;
            ddc_pkg::CMD_PRE_ONE:  bank_d[p.ba] = 1'b0;
            ddc_pkg::CMD_PRE_ALL:  bank_d = 8'h00;
            default:               bank_d = bank_d;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bank_open_q <= 8'h00;
        end else begin
            bank_open_q <= bank_d;
        end
    end

    // ------------------------------------------------------------------
    // Refresh busy and exit settle timers
    // ------------------------------------------------------------------
    logic [7:0] ref_cnt_q;   // Memory edges of refresh left
    logic [3:0] xp_cnt_q;    // Memory edges of exit settle left

    always_ff @(posedge clk) begin
        if (srst) begin
            ref_cnt_q <= 8'h00;
        end else if (cmd_c == ddc_pkg::CMD_REFRESH) begin
            ref_cnt_q <= ddc_pkg::RFC_CK;
        end else if (ck_rise && ref_cnt_q != 8'h00) begin
            ref_cnt_q <= ref_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            xp_cnt_q <= 4'h0;
        end else if (cmd_c == ddc_pkg::CMD_PD_EXIT ||
                     cmd_c == ddc_pkg::CMD_SR_EXIT) begin
            xp_cnt_q <= ddc_pkg::XP_CK;
        end else if (ck_rise && xp_cnt_q != 4'h0) begin
            xp_cnt_q <= xp_cnt_q - 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------
    // Enable low on both edges simply keeps the state
    always_ff @(posedge clk) begin
        if (srst) begin
            pwr_q <= ddc_pkg::PS_ACTIVE;
        end else begin
            case (cmd_c)
                ddc_pkg::CMD_SR_ENTER: pwr_q <= ddc_pkg::PS_SELF;
                ddc_pkg::CMD_PD_ENTER: begin
                    // Open bank or burst gives active power-down
                    if (bank_open_q != 8'h00 || burst_busy_q) begin
                        pwr_q <= ddc_pkg::PS_PD_ACT;
                    end else begin
                        pwr_q <= ddc_pkg::PS_PD_PRE;
                    end
                end
                ddc_pkg::CMD_PD_EXIT,
                ddc_pkg::CMD_SR_EXIT: pwr_q <= ddc_pkg::PS_ACTIVE;
                default: pwr_q <= pwr_q;
            endcase
        end
    end

    // Idle needs every prior timing settled
    always_ff @(posedge clk) begin
        if (srst) begin
            idle_q <= 1'b0;
        end else begin
            idle_q <= (pwr_q == ddc_pkg::PS_ACTIVE) && cke_prev_q &&
                      (bank_d == 8'h00) && !burst_busy_q &&
                      (ref_cnt_q == 8'h00) && (xp_cnt_q == 4'h0) &&
                      !zq_busy_q;
        end
    end

    // ------------------------------------------------------------------
    // Internal refresh timer, self refresh only
    // ------------------------------------------------------------------
    logic [9:0] refi_cnt_q;   // clk cycles into current interval

    // Power-down leaves refresh to the controller
    always_ff @(posedge clk) begin
        if (srst || pwr_q != ddc_pkg::PS_SELF) begin
            refi_cnt_q      <= 10'h000;
            self_ref_tick_q <= 1'b0;
        end else if (refi_cnt_q == ddc_pkg::REFI_CYC - 10'h001) begin
            refi_cnt_q      <= 10'h000;
            self_ref_tick_q <= 1'b1;
        end else begin
            refi_cnt_q      <= refi_cnt_q + 10'h001;
            self_ref_tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Calibration engine
    // ------------------------------------------------------------------
    logic [9:0] zq_cnt_q;    // Memory edges of calibration left
    logic       zq_init_q;   // A long calibration already ran

    // Busy engine ignores a second calibration command
    always_ff @(posedge clk) begin
        if (srst) begin
            zq_cnt_q    <= 10'h000;
            zq_init_q   <= 1'b0;
            zq_busy_q   <= 1'b0;
            zq_update_q <= 1'b0;
        end else begin
            zq_update_q <= 1'b0;
            if (cmd_c == ddc_pkg::CMD_CAL_LONG && !zq_busy_q) begin
                // First run gets the longer window
                zq_cnt_q  <= zq_init_q ? ddc_pkg::ZQOPER_CK :
                                         ddc_pkg::ZQINIT_CK;
                zq_init_q <= 1'b1;
                zq_busy_q <= 1'b1;
            end else if (cmd_c == ddc_pkg::CMD_CAL_SHRT && !zq_busy_q) begin
                zq_cnt_q  <= ddc_pkg::ZQCS_CK;
                zq_busy_q <= 1'b1;
            end else if (ck_rise && zq_busy_q) begin
                zq_cnt_q <= zq_cnt_q - 10'h001;
                if (zq_cnt_q == 10'h001) begin
                    // Results go to drivers and termination
                    zq_busy_q   <= 1'b0;
                    zq_update_q <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    logic acc;   // Edge where a command may be taken
    assign acc = ck_rise && pwr_q == ddc_pkg::PS_ACTIVE &&
                 cke_prev_q && p.cke;

    sequence s_pd_entry;
        ck_rise && pwr_q == ddc_pkg::PS_ACTIVE && cke_prev_q &&
        !p.cke && quiet && !(sel && strb == 3'b001);
    endsequence

    sequence s_pd_hold;
        ck_rise && !cke_prev_q && !p.cke &&
        (pwr_q == ddc_pkg::PS_PD_ACT || pwr_q == ddc_pkg::PS_PD_PRE);
    endsequence

    a_mode_set_decode: assert property (
        acc && sel && strb == 3'b000 |=> dec_valid_q &&
        dec_q.cmd == ddc_pkg::CMD_MODE_SET && dec_q.bank == $past(p.ba))
        else $error("mode set not reported with its bank");

    a_deselect_quiet: assert property (
        acc && !sel && !(burst_end && ap_pend_q) |=>
        !dec_valid_q && $stable(bank_open_q))
        else $error("deselect registered a command");

    a_burst_runs: assert property (
        burst_busy_q && ck_rise && burst_cnt_q != 3'h1 |=>
        burst_busy_q && burst_cnt_q == $past(burst_cnt_q) - 3'h1)
        else $error("burst cut short");

    a_pd_entry_state: assert property (
        s_pd_entry |=> pwr_q == ddc_pkg::PS_PD_ACT ||
        pwr_q == ddc_pkg::PS_PD_PRE)
        else $error("power-down not entered");

    a_pd_hold_state: assert property (
        s_pd_hold |=> $stable(pwr_q))
        else $error("power-down left with enable low");

    a_sr_exit_async: assert property (
        pwr_q == ddc_pkg::PS_SELF && p.cke && !ck_rise |=>
        pwr_q == ddc_pkg::PS_ACTIVE ##1 !self_ref_tick_q)
        else $error("self refresh exit missed");

    a_pd_no_tick: assert property (
        pwr_q != ddc_pkg::PS_SELF |=> !self_ref_tick_q)
        else $error("internal refresh outside self refresh");

    a_bank_activate: assert property (
        acc && sel && strb == 3'b011 |=> bank_open_q[$past(p.ba)] &&
        (bank_open_q & ~$past(bank_open_q)) == 8'h01 << $past(p.ba))
        else $error("activate touched the wrong bank");

    a_cal_update: assert property (
        ck_rise && zq_busy_q && zq_cnt_q == 10'h001 |=>
        zq_update_q && !zq_busy_q ##1 !zq_update_q)
        else $error("calibration results not transferred");

    a_idle_closed: assert property (
        idle_q |-> $past(bank_open_q != 8'h00 && !ck_rise) == 1'b0 ||
        bank_open_q == 8'h00)
        else $error("idle with a bank open");

endmodule

/* core/ddc_pkg.sv */
// Shared constants and types for the command decoder.
// Assumes every count of memory-clock edges fits the widths given here.
package ddc_pkg;

    // ------------------------------------------------------------------
    // Clock and time figures
    // ------------------------------------------------------------------
    localparam int CLK_NS    = 8;     // System clock period in ns
    localparam int T_REFI_NS = 7800;  // Internal refresh interval in ns
    // Longest interval, so rounded down to whole clk cycles
    localparam logic [9:0] REFI_CYC = 10'(T_REFI_NS / CLK_NS);

    // ------------------------------------------------------------------
    // Counts of memory-clock rising edges
    // ------------------------------------------------------------------
    localparam logic [2:0] BL8_CK    = 3'h4;    // Eight beats, two a clock
    localparam logic [2:0] BC4_CK    = 3'h2;    // Four-beat chop
    localparam logic [7:0] RFC_CK    = 8'h20;   // Refresh busy, default
    localparam logic [3:0] XP_CK     = 4'h3;    // Exit settle, default
    localparam logic [9:0] ZQINIT_CK = 10'h200; // First long calibration
    localparam logic [9:0] ZQOPER_CK = 10'h100; // Later long calibration
    localparam logic [9:0] ZQCS_CK   = 10'h040; // Short calibration

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int AP_BIT     = 10;     // Auto precharge / all banks
    localparam int CHOP_BIT   = 12;     // On-the-fly chop select
    localparam int MR0_BL_LSB = 0;      // Burst field in mode reg 0
    localparam logic [1:0] BL_FIX8  = 2'h0; // Fixed eight beats
    localparam logic [1:0] BL_OTF   = 2'h1; // Chosen per command
    localparam logic [1:0] BL_FIX4  = 2'h2; // Fixed four-beat chop
    localparam logic [1:0] MR0_RST  = 2'h0; // Burst field after reset
    localparam logic [2:0] MR0_SEL  = 3'h0; // Bank code of mode reg 0

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Command and address pins as sampled
    typedef struct packed {
        logic        cke;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [2:0]  ba;
        logic [15:0] addr;
    } ddc_pins_t;

    // Decoded command codes
    typedef enum logic [3:0] {
        CMD_NONE     = 4'h0,
        CMD_MODE_SET = 4'h1,
        CMD_REFRESH  = 4'h2,
        CMD_SR_ENTER = 4'h3,
        CMD_SR_EXIT  = 4'h4,
        CMD_PRE_ONE  = 4'h5,
        CMD_PRE_ALL  = 4'h6,
        CMD_ACTIVATE = 4'h7,
        CMD_WRITE    = 4'h8,
        CMD_READ     = 4'h9,
        CMD_PD_ENTER = 4'ha,
        CMD_PD_EXIT  = 4'hb,
        CMD_CAL_LONG = 4'hc,
        CMD_CAL_SHRT = 4'hd
    } ddc_cmd_t;

    // Power states, one-hot
    typedef enum logic [3:0] {
        PS_ACTIVE = 4'b0001,
        PS_PD_ACT = 4'b0010,
        PS_PD_PRE = 4'b0100,
        PS_SELF   = 4'b1000
    } ddc_pwr_t;

    // Decoded command as reported
    typedef struct packed {
        ddc_cmd_t    cmd;
        logic [2:0]  bank;
        logic [15:0] addr;
        logic        chop;
        logic        auto_pre;
    } ddc_dec_t;

endpackage

/* core/ddc_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk; output follows once stages
// two and three agree.
`timescale 1ns/100ps

module ddc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] s1_q;   // Metastable stage, read only by s2_q
    logic [W-1:0] s2_q;   // Second stage
    logic [W-1:0] s3_q;   // Third stage

    // ------------------------------------------------------------------
    // Shift chain
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ------------------------------------------------------------------
    // Filter: a bit moves only where stages two and three agree
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dout <= '0;
        end else begin
            dout <= (s2_q & s3_q) | (dout & (s2_q ^ s3_q));
        end
    end

endmodule

/* verification/ddc_ctrl_model.sv */
// Controller model: memory clock and command pins.
// Assumes the decoder samples both with its own clock.
`timescale 1ns/100ps

module ddc_ctrl_model (
    input  wire logic          clk,
    output logic               ck_pin,
    output ddc_pkg::ddc_pins_t pins
);
    // Free memory clock, 125 ns period, phase unrelated to clk
    initial begin
        ck_pin = 1'b0;
        forever #62.5 ck_pin = ~ck_pin;
    end
    // Idle as NOP with clock enable high
    initial pins = {5'h17, 19'h0};
    // Every pin at a defined level, changed off the clk edge
    task automatic put(input ddc_pkg::ddc_pins_t p);
        @(negedge clk);
        pins = p;
    endtask
    // Change in low phase, held across the next rise
    task automatic send(input ddc_pkg::ddc_pins_t p);
        @(negedge ck_pin);
        put(p);
        @(posedge ck_pin);
    endtask
endmodule

/* verification/ddc_decoder_bench.sv */
// Bench for the command decoder; model compared at every command sent through step.
// Assumes the controller model drives ck_pin and pins.
`timescale 1ns/100ps

module ddc_decoder_bench;
    logic               clk, rstn, ck_pin, dec_valid_q, idle_q;
    logic               rst_pin_n, burst_busy_q, zq_busy_q, zq_update_q;
    logic [7:0]         bank_open_q;
    logic [1:0]         mr0_bl_q, mr;
    logic [2:0]         b;
    ddc_pkg::ddc_pins_t pins;
    ddc_pkg::ddc_dec_t  dec_q;
    ddc_pkg::ddc_pwr_t  pwr_q;
    int                 mismatches, checked, pc, ps, ups;

    ddc_ctrl_model u_ddc_ctrl_model (.clk(clk), .ck_pin(ck_pin), .pins(pins));
    ddc_decoder u_ddc_decoder (.clk(clk), .rstn(rstn), .ck_pin(ck_pin),
        .rst_pin_n(rst_pin_n), .pins(pins), .dec_q(dec_q),
        .dec_valid_q(dec_valid_q), .pwr_q(pwr_q), .bank_open_q(bank_open_q),
        .mr0_bl_q(mr0_bl_q), .burst_busy_q(burst_busy_q), .idle_q(idle_q),
        .self_ref_tick_q(), .zq_busy_q(zq_busy_q), .zq_update_q(zq_update_q));
    // Count calibration done pulses, sampled away from the launch edge
    always @(negedge clk) if (zq_update_q === 1'b1) ups++;

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Pins from enable, strobes, bank, address
    function automatic ddc_pkg::ddc_pins_t mk(logic k, logic [3:0] c,
                                              logic [2:0] a, logic [15:0] d);
        return {k, c, a, d};
    endfunction
    // Reference decode, tracks enable and power state
    function automatic ddc_pkg::ddc_cmd_t model(ddc_pkg::ddc_pins_t p);
        ddc_pkg::ddc_cmd_t e;
        logic              q;
        q = p.cs_n | (p.ras_n & p.cas_n & p.we_n);
        e = ddc_pkg::CMD_NONE;
        if (ps != 0) begin
            if (pc == 0 && p.cke && q) e = ddc_pkg::CMD_PD_EXIT;
        end else if (pc == 1 && !p.cke) begin
            if (q) e = ddc_pkg::CMD_PD_ENTER;
            else if (p[22:19] == 4'h1) e = ddc_pkg::CMD_SR_ENTER;
        end else if (pc == 1 && !p.cs_n) begin
            case (p[21:19])
                3'h0: e = ddc_pkg::CMD_MODE_SET;
                3'h1: e = ddc_pkg::CMD_REFRESH;
                3'h2: e = p.addr[10] ? ddc_pkg::CMD_PRE_ALL : ddc_pkg::CMD_PRE_ONE;
                3'h3: e = ddc_pkg::CMD_ACTIVATE;
                3'h4: e = ddc_pkg::CMD_WRITE;
                3'h5: e = ddc_pkg::CMD_READ;
                3'h6: e = p.addr[10] ? ddc_pkg::CMD_CAL_LONG : ddc_pkg::CMD_CAL_SHRT;
                default: e = ddc_pkg::CMD_NONE;
            endcase
        end
        if (e == ddc_pkg::CMD_MODE_SET && p.ba == 3'h0) mr = p.addr[1:0];
        if (e inside {ddc_pkg::CMD_PD_ENTER, ddc_pkg::CMD_SR_ENTER}) ps = 1;
        if (e == ddc_pkg::CMD_PD_EXIT) ps = 0;
        pc = int'(p.cke);
        return e;
    endfunction
    // Compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    // One command across a memory clock rise, bounded wait
    task automatic step(input ddc_pkg::ddc_pins_t p);
        ddc_pkg::ddc_cmd_t e;
        logic              c;
        int                n;
        u_ddc_ctrl_model.send(p);
        e = model(p);
        c = (mr == ddc_pkg::BL_OTF) ? !p.addr[12] : (mr == ddc_pkg::BL_FIX4);
        n = 0;
        while (dec_valid_q !== 1'b1 && n < 12) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(dec_valid_q, e != ddc_pkg::CMD_NONE);
        if (n < 12) chk(dec_q.cmd, e);
        if (e inside {ddc_pkg::CMD_READ, ddc_pkg::CMD_WRITE})
            chk({dec_q.bank, dec_q.chop, dec_q.auto_pre}, {p.ba, c, p.addr[10]});
    endtask
    // Counts, verdict, end of run
    task automatic final_report;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Hang guard, well beyond the calibration wait
    initial begin
        #200000;
        mismatches++;
        final_report();
    end
    // Main sequence
    initial begin
        {mismatches, checked, pc, ps} = '0;
        pc = 1;
        mr = ddc_pkg::MR0_RST;
        rst_pin_n = 1'b1;
        rstn = 1'b0;
        void'($urandom(22));
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        chk({pwr_q, mr0_bl_q}, {ddc_pkg::PS_ACTIVE, ddc_pkg::MR0_RST});
        repeat (3) step(mk(1, 4'h7, 3'h0, 16'h0));
        step(mk(1, 4'h0, 3'h0, 16'h0001));
        chk(mr0_bl_q, ddc_pkg::BL_OTF);
        for (int i = 0; i < 2; i++) begin
            b = 3'($urandom % 8);
            step(mk(1, 4'h3, b, 16'($urandom)));
            chk(bank_open_q[b], 1);
            step(mk(1, 4'(5 - i), b, {3'h0, i[0], 2'h1, 10'($urandom)}));
            step(mk(1, 4'hf, b, 16'($urandom)));
            chk(burst_busy_q, 1);
            repeat (4) step(mk(1, 4'h7, 3'h0, 16'h0));
            chk({burst_busy_q, bank_open_q[b]}, 0);
            $display("burst test %0d done", i);
        end
        step(mk(1, 4'h2, b, 16'h0));
        step(mk(1, 4'h2, b, 16'h0400));
        step(mk(0, 4'h7, 3'h0, 16'h0));
        chk(pwr_q, ddc_pkg::PS_PD_PRE);
        step(mk(0, 4'h7, 3'h0, 16'h0));
        chk(pwr_q, ddc_pkg::PS_PD_PRE);
        repeat (4) step(mk(1, 4'h7, 3'h0, 16'h0));
        chk({pwr_q, idle_q}, {ddc_pkg::PS_ACTIVE, 1'b1});
        $display("power-down test done");
        step(mk(0, 4'h1, 3'h0, 16'h0));
        chk(pwr_q, ddc_pkg::PS_SELF);
        u_ddc_ctrl_model.send(mk(0, 4'h7, 3'h0, 16'h0));
        repeat (3) @(posedge clk);
        u_ddc_ctrl_model.put(mk(1, 4'h7, 3'h0, 16'h0));
        repeat (8) @(posedge clk);
        #1;
        chk(pwr_q, ddc_pkg::PS_ACTIVE);
        {ps, pc} = {32'h0, 32'h1};
        repeat (3) step(mk(1, 4'h7, 3'h0, 16'h0));
        step(mk(1, 4'h6, 3'h0, 16'h0400));
        chk(zq_busy_q, 1);
        step(mk(1, 4'h6, 3'h0, 16'h0));
        step(mk(1, 4'h1, 3'h0, 16'h0));
        u_ddc_ctrl_model.send(mk(1, 4'h7, 3'h0, 16'h0));
        repeat (520) @(posedge ck_pin);
        chk(ups, 1);
        $display("calibration and refresh test done");
        @(negedge clk) rst_pin_n = 1'b0;
        repeat (8) @(negedge clk);
        chk({pwr_q, mr0_bl_q, zq_busy_q},
            {ddc_pkg::PS_ACTIVE, ddc_pkg::MR0_RST, 1'b0});
        $display("reset pin test done");
        final_report();
    end
endmodule
